// >>> codec_dac_adc_control_regs.sv
// What this block does
// - Muting or zero volume raises the DAC zero flag unless its disable bit is 1.
// - Zero input data raises the DAC zero flag unless its disable bit is 1.
// - The polarity bit makes the zero flag pins active low at 0 and active high at 1.
// - Bit 6 of the pin function register makes the shared pin a left zero flag or interrupt.
// - In interrupt mode, code 00 puts the right flag and code 01 the left flag on the right pin.
// - Code 10 asserts the right pin when either channel is zero.
// - Code 11 asserts the right pin only when both channels are zero.
// - The left volume code attenuates 0.375 dB per step below full scale at code 127.
// - The right volume code uses the same scale as the left.
// - The left peak level reads as a six-bit count of dB below full scale.
// - The right peak level reads the same way.
// - Left gain steps 0.5 dB per code and saturates at 24 dB from code 48 upward.
// - Right gain behaves the same way.
// - Modulator clock is MCLK/2 at 0 and MCLK/4 at 1; the filter bit enables the high-pass.
// - Each power-down bit set to 1 powers down its section.
// - Each ADC mute bit silences its own channel when 1.
`timescale 1ns/1ps
module codec_dac_adc_control_regs
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Register port from the serial control interface
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [6:0] regAddr,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata_q,
  output logic regRvalid_q,
  // DAC channel state
  input wire logic dacLeftDataZero,
  input wire logic dacRightDataZero,
  input wire logic dacLeftMuted,
  input wire logic dacRightMuted,
  input wire logic [5:0] dacLeftPeakIn,
  input wire logic [5:0] dacRightPeakIn,
  // Interrupt source for the shared pin
  input wire logic interruptIn,
  // ADC modulator master clock enable
  input wire logic adcMclkEn,
  // Pins
  output logic sharedZeroIntPin_q,
  output logic rightZeroPin_q,
  // DAC volume
  output logic [6:0] dacLeftAttenuation_q,
  output logic [6:0] dacRightAttenuation_q,
  // ADC gain and control
  output logic [5:0] leftGainSteps_q,
  output logic [5:0] rightGainSteps_q,
  output logic adcModEn_q,
  output codec_regs_pkg::adc_ctrl_t adcCtrl_q
);
  import codec_regs_pkg::*;

  // ------------------------------------------------------------
  // Register storage
  // ------------------------------------------------------------
  logic [2:0] zeroFlagCfg_q;
  logic [2:0] zeroPinFunc_q;
  logic [6:0] leftVol_q;
  logic [6:0] rightVol_q;
  logic [5:0] leftGainCode_q;
  logic [5:0] rightGainCode_q;
  logic [7:0] adcMain_q;
  logic [5:0] leftPeak_q;
  logic [5:0] rightPeak_q;

  // ------------------------------------------------------------
  // Write decode
  // ------------------------------------------------------------
  // Peak and unmapped offsets have no select, so such writes are lost
  logic wrZeroFlagCfg;
  logic wrZeroPinFunc;
  logic wrLeftVol;
  logic wrRightVol;
  logic wrLeftGain;
  logic wrRightGain;
  logic wrAdcMain;

  assign wrZeroFlagCfg = regWrite && (regAddr == ADDR_DAC_ZERO_FLAG_CONFIG);
  assign wrZeroPinFunc = regWrite && (regAddr == ADDR_DAC_ZERO_PIN_FUNCTION);
  assign wrLeftVol = regWrite && (regAddr == ADDR_DAC_LEFT_VOLUME);
  assign wrRightVol = regWrite && (regAddr == ADDR_DAC_RIGHT_VOLUME);
  assign wrLeftGain = regWrite && (regAddr == ADDR_ADC_LEFT_INPUT_GAIN);
  assign wrRightGain = regWrite && (regAddr == ADDR_ADC_RIGHT_INPUT_GAIN);
  assign wrAdcMain = regWrite && (regAddr == ADDR_ADC_MAIN_CONTROL);

  // Reserved bits are never stored, so they read back as zero
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      zeroFlagCfg_q <= RST_ZERO_FLAG_CONFIG[2:0];
    else if (wrZeroFlagCfg)
      zeroFlagCfg_q <= regWdata[BIT_ZF_VOL_DIS:BIT_ZF_POL];
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      zeroPinFunc_q <= RST_ZERO_PIN_FUNCTION[6:4];
    else if (wrZeroPinFunc)
      zeroPinFunc_q <= regWdata[BIT_INT_SEL:BIT_ZSEL_LO];
  end

  // Bit 7 of a volume byte is reserved
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      leftVol_q <= RST_VOLUME[6:0];
      rightVol_q <= RST_VOLUME[6:0];
    end
    else
    begin
      if (wrLeftVol)
        leftVol_q <= regWdata[6:0];
      if (wrRightVol)
        rightVol_q <= regWdata[6:0];
    end
  end

  // Top two bits of a gain byte are reserved
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      leftGainCode_q <= RST_INPUT_GAIN[5:0];
      rightGainCode_q <= RST_INPUT_GAIN[5:0];
    end
    else
    begin
      if (wrLeftGain)
        leftGainCode_q <= regWdata[5:0];
      if (wrRightGain)
        rightGainCode_q <= regWdata[5:0];
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      adcMain_q <= RST_ADC_MAIN_CONTROL;
    else if (wrAdcMain)
      adcMain_q <= regWdata;
  end

  // ------------------------------------------------------------
  // Peak capture
  // ------------------------------------------------------------
  // Sampled so a read sees a stable code
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      leftPeak_q <= RST_PEAK_LEVEL;
      rightPeak_q <= RST_PEAK_LEVEL;
    end
    else
    begin
      leftPeak_q <= dacLeftPeakIn;
      rightPeak_q <= dacRightPeakIn;
    end
  end

  // ------------------------------------------------------------
  // Read port
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      regRdata_q <= 8'h00;
      regRvalid_q <= 1'b0;
    end
    else
    begin
      regRvalid_q <= regRead;
      if (regRead)
      begin
        unique case (regAddr)
          ADDR_DAC_ZERO_FLAG_CONFIG: regRdata_q <= {5'h00, zeroFlagCfg_q};
          ADDR_DAC_ZERO_PIN_FUNCTION: regRdata_q <= {1'b0, zeroPinFunc_q, 4'h0};
          ADDR_DAC_LEFT_VOLUME: regRdata_q <= {1'b0, leftVol_q};
          ADDR_DAC_RIGHT_VOLUME: regRdata_q <= {1'b0, rightVol_q};
          ADDR_DAC_LEFT_PEAK_LEVEL: regRdata_q <= {2'h0, leftPeak_q};
          ADDR_DAC_RIGHT_PEAK_LEVEL: regRdata_q <= {2'h0, rightPeak_q};
          ADDR_ADC_LEFT_INPUT_GAIN: regRdata_q <= {2'h0, leftGainCode_q};
          ADDR_ADC_RIGHT_INPUT_GAIN: regRdata_q <= {2'h0, rightGainCode_q};
          ADDR_ADC_MAIN_CONTROL: regRdata_q <= adcMain_q;
          default: regRdata_q <= 8'h00;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // Zero detection
  // ------------------------------------------------------------
  logic leftZero;
  logic rightZero;
  dac_chan_t leftChan;
  dac_chan_t rightChan;

  // Volume code travels with the mute and data state
  assign leftChan = {leftVol_q, dacLeftMuted, dacLeftDataZero};
  assign rightChan = {rightVol_q, dacRightMuted, dacRightDataZero};

  zero_detect leftDetect (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .chan(leftChan),
    .volDisable(zeroFlagCfg_q[BIT_ZF_VOL_DIS]),
    .dataDisable(zeroFlagCfg_q[BIT_ZF_DATA_DIS]),
    .zeroFlag_q(leftZero)
  );

  zero_detect rightDetect (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .chan(rightChan),
    .volDisable(zeroFlagCfg_q[BIT_ZF_VOL_DIS]),
    .dataDisable(zeroFlagCfg_q[BIT_ZF_DATA_DIS]),
    .zeroFlag_q(rightZero)
  );

  // ------------------------------------------------------------
  // Pin functions
  // ------------------------------------------------------------
  zero_sel_t right_zero_pin_function;
  logic rightPinActive;
  logic intMode;
  logic polHigh;

  assign intMode = zeroPinFunc_q[BIT_INT_SEL - BIT_ZSEL_LO];
  assign right_zero_pin_function = zero_sel_t'(zeroPinFunc_q[1:0]);
  assign polHigh = zeroFlagCfg_q[BIT_ZF_POL];

  always_comb
  begin
    // Outside interrupt mode the right pin keeps its plain role
    rightPinActive = rightZero;
    if (intMode)
    begin
      unique case (right_zero_pin_function)
        ZSEL_RIGHT: rightPinActive = rightZero;
        ZSEL_LEFT: rightPinActive = leftZero;
        ZSEL_EITHER: rightPinActive = leftZero || rightZero;
        ZSEL_BOTH: rightPinActive = leftZero && rightZero;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      // Reset polarity is active low, so idle level is high
      sharedZeroIntPin_q <= 1'b1;
      rightZeroPin_q <= 1'b1;
    end
    else
    begin
      // Polarity also applied to interrupt, keeping one pin convention
      sharedZeroIntPin_q <= (intMode ? interruptIn : leftZero) ~^ polHigh;
      rightZeroPin_q <= rightPinActive ~^ polHigh;
    end
  end

  // ------------------------------------------------------------
  // Volume and gain
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      dacLeftAttenuation_q <= 7'h00;
      dacRightAttenuation_q <= 7'h00;
    end
    else
    begin
      // Steps of 0.375 dB below full scale
      dacLeftAttenuation_q <= ~leftVol_q;
      dacRightAttenuation_q <= ~rightVol_q;
    end
  end

  gain_map leftGain (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .gainCode(leftGainCode_q),
    .gainSteps_q(leftGainSteps_q)
  );

  gain_map rightGain (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .gainCode(rightGainCode_q),
    .gainSteps_q(rightGainSteps_q)
  );

  // ------------------------------------------------------------
  // ADC control
  // ------------------------------------------------------------
  logic [1:0] modCount_q;
  logic [1:0] modLast;

  assign modLast = adcMain_q[BIT_AMC] ? MOD_DIV4_LAST : MOD_DIV2_LAST;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      modCount_q <= 2'h0;
      adcModEn_q <= 1'b0;
    end
    else
    begin
      adcModEn_q <= 1'b0;
      if (adcMclkEn)
      begin
        if (modCount_q >= modLast)
        begin
          modCount_q <= 2'h0;
          adcModEn_q <= 1'b1;
        end
        else
          modCount_q <= modCount_q + 2'h1;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      adcCtrl_q <= adc_ctrl_t'(RST_ADC_MAIN_CONTROL);
    else
    begin
      adcCtrl_q.modClkDiv4 <= adcMain_q[BIT_AMC];
      adcCtrl_q.highpassEnable <= adcMain_q[BIT_HPF];
      adcCtrl_q.adcPowerdown <= adcMain_q[BIT_ADC_POWERDOWN];
      adcCtrl_q.adcAnalogPowerdown <= adcMain_q[BIT_ADC_ANALOG_POWERDOWN];
      adcCtrl_q.adcMuteRight <= adcMain_q[BIT_MUTE_R];
      adcCtrl_q.adcMuteLeft <= adcMain_q[BIT_MUTE_L];
      adcCtrl_q.leftGainAmpPowerdown <= adcMain_q[BIT_PGA_L_PD];
      adcCtrl_q.rightGainAmpPowerdown <= adcMain_q[BIT_PGA_R_PD];
    end
  end

endmodule

// >>> codec_regs_pkg.sv
package codec_regs_pkg;

  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [6:0] ADDR_DAC_ZERO_FLAG_CONFIG = 7'h66;
  localparam logic [6:0] ADDR_DAC_ZERO_PIN_FUNCTION = 7'h67;
  localparam logic [6:0] ADDR_DAC_LEFT_VOLUME = 7'h68;
  localparam logic [6:0] ADDR_DAC_RIGHT_VOLUME = 7'h69;
  localparam logic [6:0] ADDR_DAC_LEFT_PEAK_LEVEL = 7'h6a;
  localparam logic [6:0] ADDR_DAC_RIGHT_PEAK_LEVEL = 7'h6b;
  localparam logic [6:0] ADDR_ADC_LEFT_INPUT_GAIN = 7'h6c;
  localparam logic [6:0] ADDR_ADC_RIGHT_INPUT_GAIN = 7'h6d;
  localparam logic [6:0] ADDR_ADC_MAIN_CONTROL = 7'h6e;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int BIT_ZF_VOL_DIS = 2;
  localparam int BIT_ZF_DATA_DIS = 1;
  localparam int BIT_ZF_POL = 0;
  localparam int BIT_INT_SEL = 6;
  localparam int BIT_ZSEL_HI = 5;
  localparam int BIT_ZSEL_LO = 4;
  localparam int BIT_AMC = 7;
  localparam int BIT_HPF = 6;
  localparam int BIT_ADC_POWERDOWN = 5;
  localparam int BIT_ADC_ANALOG_POWERDOWN = 4;
  localparam int BIT_MUTE_R = 3;
  localparam int BIT_MUTE_L = 2;
  localparam int BIT_PGA_L_PD = 1;
  localparam int BIT_PGA_R_PD = 0;

  // ------------------------------------------------------------
  // Reset values and codes
  // ------------------------------------------------------------
  localparam logic [7:0] RST_ZERO_FLAG_CONFIG = 8'h00;
  localparam logic [7:0] RST_ZERO_PIN_FUNCTION = 8'h00;
  localparam logic [7:0] RST_VOLUME = 8'h7f;
  localparam logic [7:0] RST_INPUT_GAIN = 8'h00;
  localparam logic [7:0] RST_ADC_MAIN_CONTROL = 8'h00;
  localparam logic [5:0] RST_PEAK_LEVEL = 6'h3f;
  localparam logic [5:0] GAIN_SAT_CODE = 6'h30;
  localparam logic [5:0] GAIN_MAX_STEP = 6'h30;
  // Divider for modulator enable: /2 -> 128 fs, /4 -> 64 fs
  localparam logic [1:0] MOD_DIV2_LAST = 2'h1;
  localparam logic [1:0] MOD_DIV4_LAST = 2'h3;

  typedef enum logic [1:0] {
    ZSEL_RIGHT = 2'b00,
    ZSEL_LEFT = 2'b01,
    ZSEL_EITHER = 2'b10,
    ZSEL_BOTH = 2'b11
  } zero_sel_t;

  typedef struct packed {
    logic modClkDiv4;
    logic highpassEnable;
    logic adcPowerdown;
    logic adcAnalogPowerdown;
    logic adcMuteRight;
    logic adcMuteLeft;
    logic leftGainAmpPowerdown;
    logic rightGainAmpPowerdown;
  } adc_ctrl_t;

  typedef struct packed {
    logic [6:0] attenuation;
    logic muted;
    logic dataZero;
  } dac_chan_t;

endpackage

// >>> zero_detect.sv
`timescale 1ns/1ps
module zero_detect
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Channel state
  input wire codec_regs_pkg::dac_chan_t chan,
  // Disables
  input wire logic volDisable,
  input wire logic dataDisable,
  // Flag, active high internally
  output logic zeroFlag_q
);
  import codec_regs_pkg::*;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      zeroFlag_q <= 1'b0;
    else
      zeroFlag_q <= (!volDisable && (chan.muted || chan.attenuation == 7'h00))
        || (!dataDisable && chan.dataZero);
  end
endmodule

// >>> gain_map.sv
`timescale 1ns/1ps
module gain_map
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Gain code from register
  input wire logic [5:0] gainCode,
  // Effective half-dB step count, 0..48
  output logic [5:0] gainSteps_q
);
  import codec_regs_pkg::*;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      gainSteps_q <= 6'h00;
    else if (gainCode >= GAIN_SAT_CODE)
      gainSteps_q <= GAIN_MAX_STEP;
    else
      gainSteps_q <= gainCode;
  end
endmodule

// >>> codec_regs_checker.sv
`timescale 1ns/1ps
module codec_regs_checker (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Register port
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [6:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic [7:0] regRdata_q,
  // Watched side
  input wire logic [5:0] dacLeftPeakIn,
  input wire logic adcMclkEn,
  input wire logic adcModEn_q,
  input wire logic [6:0] dacLeftAttenuation_q,
  input wire logic [5:0] leftGainSteps_q,
  input wire logic [5:0] rightGainSteps_q,
  input wire codec_regs_pkg::adc_ctrl_t adcCtrl_q
);
  import codec_regs_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // Two-deep history: writes land, then reach outputs
  logic [7:0] wd1_q, wd2_q;
  logic [5:0] pk1_q, pk2_q;
  always_ff @(posedge clk_sys)
  begin
    wd1_q <= regWdata;
    wd2_q <= wd1_q;
    pk1_q <= dacLeftPeakIn;
    pk2_q <= pk1_q;
  end
  unmapped_read_a: assert property (regRead && (regAddr < 7'h66 || regAddr > 7'h6e)
    |=> regRdata_q == 8'h00) else $error("unmapped read not zero");
  reserved_bits_a: assert property (regRead && regAddr == ADDR_DAC_ZERO_FLAG_CONFIG
    |=> regRdata_q[7:3] == 5'h00) else $error("reserved bits set");
  left_peak_a: assert property (regRead && regAddr == ADDR_DAC_LEFT_PEAK_LEVEL
    |=> regRdata_q == {2'h0, pk2_q}) else $error("left peak wrong");
  left_atten_a: assert property (regWrite && regAddr == ADDR_DAC_LEFT_VOLUME
    |=> ##1 dacLeftAttenuation_q == ~wd2_q[6:0]) else $error("left attenuation wrong");
  gain_sat_a: assert property (regWrite && regAddr == ADDR_ADC_LEFT_INPUT_GAIN
    && regWdata[5:0] >= 6'h30 |=> ##1 leftGainSteps_q == 6'h30) else $error("gain not 24 dB");
  right_gain_a: assert property (regWrite && regAddr == ADDR_ADC_RIGHT_INPUT_GAIN
    |=> ##1 rightGainSteps_q == (wd2_q[5:0] > 6'h2f ? 6'h30 : wd2_q[5:0]))
    else $error("right gain wrong");
  adc_ctrl_a: assert property (regWrite && regAddr == ADDR_ADC_MAIN_CONTROL
    |=> ##1 adcCtrl_q == wd2_q) else $error("adc control wrong");
  mod_follows_a: assert property (adcModEn_q |-> $past(adcMclkEn))
    else $error("modulator pulse without clock");
  mod_gap_a: assert property (adcModEn_q |=> !adcModEn_q)
    else $error("modulator pulse too close");
  cover property (regWrite && regAddr == ADDR_ADC_MAIN_CONTROL);
  cover property (adcModEn_q && adcCtrl_q.modClkDiv4);
  cover property (regRead && regAddr == ADDR_DAC_LEFT_PEAK_LEVEL);
endmodule
bind codec_dac_adc_control_regs codec_regs_checker chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
  .regRdata_q(regRdata_q), .dacLeftPeakIn(dacLeftPeakIn), .adcMclkEn(adcMclkEn),
  .adcModEn_q(adcModEn_q), .dacLeftAttenuation_q(dacLeftAttenuation_q),
  .leftGainSteps_q(leftGainSteps_q), .rightGainSteps_q(rightGainSteps_q),
  .adcCtrl_q(adcCtrl_q));

// >>> host_port_model.sv
`timescale 1ns/1ps
module host_port_model (
  // Clock
  input wire logic clk_sys,
  // Register port
  output logic regWrite,
  output logic regRead,
  output logic [6:0] regAddr,
  output logic [7:0] regWdata,
  input wire logic [7:0] regRdata_q,
  input wire logic regRvalid_q
);
  initial
  begin
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 7'h00;
    regWdata = 8'h00;
  end
  // Data flips after release so stale bytes never pass
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    regAddr = a;
    regWdata = d;
    regWrite = 1'b1;
    @(negedge clk_sys);
    regWrite = 1'b0;
    regWdata = ~d;
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d, output logic v);
    @(negedge clk_sys);
    regAddr = a;
    regRead = 1'b1;
    @(negedge clk_sys);
    regRead = 1'b0;
    d = regRdata_q;
    v = regRvalid_q;
  endtask
endmodule

// >>> testbench.sv
`timescale 1ns/1ps
module testbench;
  import codec_regs_pkg::*;
  logic clk_sys, sys_rst, regWrite, regRead, regRvalid_q, interruptIn, adcMclkEn;
  logic dacLeftDataZero, dacRightDataZero, dacLeftMuted, dacRightMuted;
  logic sharedZeroIntPin_q, rightZeroPin_q, adcModEn_q;
  logic [6:0] regAddr, dacLeftAttenuation_q, dacRightAttenuation_q;
  logic [7:0] regWdata, regRdata_q;
  logic [5:0] dacLeftPeakIn, dacRightPeakIn, leftGainSteps_q, rightGainSteps_q;
  adc_ctrl_t adcCtrl_q;
  logic [31:0] seed, mseed;
  logic [7:0] mirror [0:8];
  int errors, check_count, modSince;
  logic modExp;
  localparam logic [7:0] MASK [0:8] = '{8'h07, 8'h70, 8'h7f, 8'h7f, 8'h00, 8'h00,
    8'h3f, 8'h3f, 8'hff};
  localparam logic [7:0] RSTV [0:8] = '{8'h00, 8'h00, 8'h7f, 8'h7f, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00};
  localparam logic [6:0] DA [0:6] = '{7'h6c, 7'h6d, 7'h6c, 7'h68, 7'h69, 7'h6a, 7'h67};
  localparam logic [7:0] DD [0:6] = '{8'h2f, 8'h30, 8'hff, 8'h80, 8'h00, 8'h55, 8'h7f};
  codec_dac_adc_control_regs DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .regWrite(regWrite),
    .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata_q(regRdata_q),
    .regRvalid_q(regRvalid_q), .dacLeftDataZero(dacLeftDataZero),
    .dacRightDataZero(dacRightDataZero), .dacLeftMuted(dacLeftMuted),
    .dacRightMuted(dacRightMuted), .dacLeftPeakIn(dacLeftPeakIn),
    .dacRightPeakIn(dacRightPeakIn), .interruptIn(interruptIn), .adcMclkEn(adcMclkEn),
    .sharedZeroIntPin_q(sharedZeroIntPin_q), .rightZeroPin_q(rightZeroPin_q),
    .dacLeftAttenuation_q(dacLeftAttenuation_q), .dacRightAttenuation_q(dacRightAttenuation_q),
    .leftGainSteps_q(leftGainSteps_q), .rightGainSteps_q(rightGainSteps_q),
    .adcModEn_q(adcModEn_q), .adcCtrl_q(adcCtrl_q));
  host_port_model host (.clk_sys(clk_sys), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata_q(regRdata_q), .regRvalid_q(regRvalid_q));
  // ----
  // Helpers
  // ----
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [5:0] sat(input logic [5:0] g);
    return g > 6'h2f ? 6'h30 : g;
  endfunction
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Sparse zero causes, so flags go both ways
  task automatic drive_inputs;
    seed = lfsr(seed);
    dacLeftDataZero = seed[0] & seed[1];
    dacRightDataZero = seed[2] & seed[3];
    dacLeftMuted = seed[4] & seed[5];
    dacRightMuted = seed[6] & seed[7];
    interruptIn = seed[8];
    dacLeftPeakIn = seed[14:9];
    dacRightPeakIn = seed[20:15];
  endtask
  task automatic apply_reset;
    sys_rst = 1'b1;
    for (int i = 0; i < 9; i++)
      mirror[i] = RSTV[i];
    repeat (12) @(negedge clk_sys);
    sys_rst = 1'b0;
  endtask
  task automatic put(input logic [6:0] a, input logic [7:0] d);
    host.wr(a, d);
    if (a >= 7'h66 && a <= 7'h6e)
      mirror[a - 7'h66] = d & MASK[a - 7'h66];
  endtask
  task automatic verify_all;
    logic [7:0] d, c, p;
    logic v, zl, zr, z;
    c = mirror[0];
    p = mirror[1];
    repeat (4) @(negedge clk_sys);
    for (int i = 0; i < 10; i++)
    begin
      host.rd(7'(i + 'h66), d, v);
      check({7'h0, v}, 8'h01);
      if (i == 9)
        check(d, 8'h00);
      else if (i == 4)
        check(d, {2'h0, dacLeftPeakIn});
      else if (i == 5)
        check(d, {2'h0, dacRightPeakIn});
      else
        check(d, mirror[i]);
    end
    check({1'b0, dacLeftAttenuation_q}, {1'b0, ~mirror[2][6:0]});
    check({1'b0, dacRightAttenuation_q}, {1'b0, ~mirror[3][6:0]});
    check({2'h0, leftGainSteps_q}, {2'h0, sat(mirror[6][5:0])});
    check({2'h0, rightGainSteps_q}, {2'h0, sat(mirror[7][5:0])});
    check(adcCtrl_q, mirror[8]);
    zl = (!c[2] && (dacLeftMuted || mirror[2][6:0] == 0)) || (!c[1] && dacLeftDataZero);
    zr = (!c[2] && (dacRightMuted || mirror[3][6:0] == 0)) || (!c[1] && dacRightDataZero);
    z = !p[6] || p[5:4] == 0 ? zr : p[5:4] == 1 ? zl : p[5:4] == 2 ? zl | zr : zl & zr;
    check({7'h0, sharedZeroIntPin_q}, {7'h0, (p[6] ? interruptIn : zl) ^ !c[0]});
    check({7'h0, rightZeroPin_q}, {7'h0, z ^ !c[0]});
  endtask
  // ----
  // Clock, modulator enables, watchdog
  // ----
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(negedge clk_sys)
  begin
    mseed = lfsr(mseed);
    adcMclkEn = mseed[0];
  end
  initial
  begin
    #80000;
    errors++;
    close_out;
  end
  // Divider model: clock pulses counted since the last modulator pulse
  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      modSince <= 0;
      modExp <= 1'b0;
    end
    else
    begin
      modExp <= 1'b0;
      if (adcMclkEn && modSince + 1 >= (mirror[8][BIT_AMC] ? 4 : 2))
      begin
        modSince <= 0;
        modExp <= 1'b1;
      end
      else if (adcMclkEn)
        modSince <= modSince + 1;
    end
  end
  always @(negedge clk_sys)
  begin
    if (!sys_rst)
      check({7'h0, adcModEn_q}, {7'h0, modExp});
  end
  // ----
  // Main sequence
  // ----
  initial
  begin
    errors = 0;
    check_count = 0;
    seed = 32'h8e6d;
    mseed = 32'h8e6d;
    drive_inputs;
    apply_reset;
    repeat (3) @(negedge clk_sys);
    verify_all;
    $display("test reset values done");
    for (int i = 0; i < 7; i++)
    begin
      put(DA[i], DD[i]);
      verify_all;
    end
    $display("test boundary writes done");
    // A reset in mid-run must bring every register back
    apply_reset;
    verify_all;
    $display("test mid-run reset done");
    for (int i = 0; i < 80; i++)
    begin
      seed = lfsr(seed);
      put(7'(seed[3:0] % 10 + 'h66), seed[15:8]);
      drive_inputs;
      verify_all;
    end
    $display("test random traffic done");
    close_out;
  end
endmodule
